// File: host_port_pin_function_select_test.sv
// bench for hpfs_top with the host pin model
// assumes hpfs_monitor is bound to the design
`timescale 1ns/10ps
`default_nettype none
module host_port_pin_function_select_test
    import hpfs_pkg::*;
;
    logic clk_sys = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic stop_mode = 1'b0, host_req_core = 1'b0, xmit_req_core = 1'b0, recv_req_core = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd_q;
    logic [2:0] host_val = 3'h0, host_en = 3'h0, pin_in, pin_out, pin_oe, gpio_in;
    logic pready, pslverr, rd_e, host_chip_select_in, host_addr_line_ten, host_acknowledge_in;
    int bad_count = 0;
    int checks = 0;
    hpfs_top DUT (.clk_sys, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .stop_mode, .host_req_core, .xmit_req_core, .recv_req_core, .pin_in, .pin_out,
        .pin_oe, .host_chip_select_in, .host_addr_line_ten, .host_acknowledge_in, .gpio_in);
    hpfs_host u_host (.pin_out, .pin_oe, .host_val, .host_en, .pin_in);
    initial begin
        forever #2.5 clk_sys = ~clk_sys;
    end
    // ****
    // bus and check helpers
    // ****
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        // answer taken at the rising edge that ends the access, before it updates
        @(posedge clk_sys);
        while (pready !== 1'b1) @(posedge clk_sys);
        rd_q = prdata;
        rd_e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
        checks++;
        if (g !== x) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", n, x, g);
        end
    endtask
    // four falling edges through the pin synchroniser
    task automatic st();
        repeat (4) @(negedge clk_sys);
    endtask
    function automatic logic [31:0] rq(logic q, logic p, logic o);
        return 32'({!o || q, (!o || q) && (q ~^ p)});
    endfunction
    function automatic logic [31:0] ob(int i);
        return 32'({pin_oe[i], pin_oe[i] & pin_out[i]});
    endfunction
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic t_regs();
        apb(1'b0, HPFS_OFS_CFG, 32'h0);
        chk("cfg reset", 32'(HPFS_RST_CFG), rd_q);
        apb(1'b0, 8'h18, 32'h0);
        chk("unmapped err", 32'h1, 32'(rd_e));
        chk("unmapped data", HPFS_RD_ZERO, rd_q);
        chk("idle oe", 32'h2, 32'(pin_oe));
        chk("idle req", 32'h1, 32'(pin_out[1]));
        $display("t_regs done");
    endtask
    task automatic t_gpio();
        apb(1'b1, HPFS_OFS_DIR, 32'h5);
        apb(1'b1, HPFS_OFS_DATA, 32'h5);
        st();
        chk("host oe", 32'h2, 32'(pin_oe));
        apb(1'b1, HPFS_OFS_CTRL, 32'h7);
        st();
        chk("gpio no mux", 32'h3f, 32'({pin_oe, pin_out}));
        apb(1'b1, HPFS_OFS_CFG, 32'h1);
        host_en <= 3'h2;
        host_val <= 3'h2;
        st();
        chk("gpio mux", 32'h2d, 32'({pin_oe, pin_out}));
        chk("gpio in", 32'h1, 32'(gpio_in[1]));
        @(posedge clk_sys);
        stop_mode <= 1'b1;
        host_val <= 3'h0;
        st();
        chk("stop oe", 32'h0, 32'(pin_oe));
        chk("stop hold", 32'h1, 32'(gpio_in[1]));
        @(posedge clk_sys);
        stop_mode <= 1'b0;
        st();
        chk("wake in", 32'h0, 32'(gpio_in[1]));
        apb(1'b1, HPFS_OFS_CTRL, 32'h0);
        $display("t_gpio done");
    endtask
    task automatic t_host();
        for (int p = 0; p < 8; p++) begin
            apb(1'b1, HPFS_OFS_CFG, {26'h0, p[1], 2'h0, p[1], 1'b0, p[0]});
            host_en <= 3'h5;
            host_val <= {p[2], 1'b0, p[2]};
            st();
            chk("chip select", 32'(!p[0] && p[2] == p[1]), 32'(host_chip_select_in));
            chk("addr ten", 32'(p[0] && p[2]), 32'(host_addr_line_ten));
            chk("ack", 32'(p[2] == p[1]), 32'(host_acknowledge_in));
        end
        @(posedge clk_sys);
        host_en <= 3'h0;
        $display("t_host done");
    endtask
    task automatic t_req();
        logic q14;
        for (int c = 0; c < 16; c++) begin
            q14 = c[0] ? !c[3] : c[3];
            apb(1'b1, HPFS_OFS_CFG, {27'h0, c[2], c[1], 1'b0, c[0], 1'b0});
            host_req_core <= c[3];
            xmit_req_core <= !c[3];
            recv_req_core <= c[3];
            st();
            chk("pin14 req", rq(q14, c[1], c[2]), ob(1));
            chk("pin15 req", c[0] ? rq(c[3], c[1], c[2]) : 32'h0, ob(2));
        end
        $display("t_req done");
    endtask
    initial begin
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        t_regs();
        t_gpio();
        t_host();
        t_req();
        report_and_stop();
    end
    // watchdog at 4000 cycles, well past the roughly 220 cycles the tests need
    initial begin
        #20000;
        bad_count++;
        report_and_stop();
    end
endmodule // host_port_pin_function_select_test
`default_nettype wire

// File: hpfs_apb.sv
// apb slave holding the control, direction, data and config registers
// assumes apb master on clk_sys; answers in the access cycle (no wait)
`timescale 1ns/10ps
`default_nettype none
module hpfs_apb
    import hpfs_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [HPFS_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [HPFS_NPIN-1:0] pin_state,
    input wire logic [HPFS_HST_W-1:0] host_state,
    output logic [HPFS_NPIN-1:0] ctrl_val,
    output logic [HPFS_NPIN-1:0] dir_val,
    output logic [HPFS_NPIN-1:0] data_val,
    output logic [HPFS_CFG_W-1:0] cfg_val
);
    logic [HPFS_NPIN-1:0] ctrl_reg, ctrl_next;
    logic [HPFS_NPIN-1:0] dir_reg, dir_next;
    logic [HPFS_NPIN-1:0] data_reg, data_next;
    logic [HPFS_CFG_W-1:0] cfg_reg, cfg_next;
    logic [31:0] rdata_reg, rdata_next;
    logic err_reg, err_next;
    logic access;
    logic hit;

    function automatic logic addr_known(input logic [HPFS_ADDR_W-1:0] a);
        return (a == HPFS_OFS_CTRL) || (a == HPFS_OFS_DIR) || (a == HPFS_OFS_DATA)
            || (a == HPFS_OFS_CFG) || (a == HPFS_OFS_PINS) || (a == HPFS_OFS_HOST);
    endfunction

    assign access = psel && penable;
    assign hit = addr_known(paddr);

    always_comb begin
        ctrl_next = ctrl_reg;
        dir_next = dir_reg;
        data_next = data_reg;
        cfg_next = cfg_reg;
        rdata_next = rdata_reg;
        err_next = 1'b0;
        // setup cycle prepares read data and error so both come from flops
        if (psel && !penable) begin
            err_next = !hit;
            unique case (paddr)
                HPFS_OFS_CTRL: rdata_next = {29'h0, ctrl_reg};
                HPFS_OFS_DIR: rdata_next = {29'h0, dir_reg};
                HPFS_OFS_DATA: rdata_next = {29'h0, data_reg};
                HPFS_OFS_CFG: rdata_next = {26'h0, cfg_reg};
                HPFS_OFS_PINS: rdata_next = {29'h0, pin_state};
                HPFS_OFS_HOST: rdata_next = {29'h0, host_state};
                default: rdata_next = HPFS_RD_ZERO;
            endcase
        end
        if (access && pwrite) begin
            unique case (paddr)
                HPFS_OFS_CTRL: ctrl_next = pwdata[HPFS_NPIN-1:0];
                HPFS_OFS_DIR: dir_next = pwdata[HPFS_NPIN-1:0];
                HPFS_OFS_DATA: data_next = pwdata[HPFS_NPIN-1:0];
                HPFS_OFS_CFG: cfg_next = pwdata[HPFS_CFG_W-1:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ctrl_reg <= HPFS_RST_CTRL;
            dir_reg <= HPFS_RST_DIR;
            data_reg <= HPFS_RST_DATA;
            cfg_reg <= HPFS_RST_CFG;
            rdata_reg <= HPFS_RD_ZERO;
            err_reg <= 1'b0;
        end else begin
            ctrl_reg <= ctrl_next;
            dir_reg <= dir_next;
            data_reg <= data_next;
            cfg_reg <= cfg_next;
            rdata_reg <= rdata_next;
            err_reg <= err_next;
        end
    end

    assign pready = 1'b1;
    assign prdata = rdata_reg;
    assign pslverr = access && err_reg;
    assign ctrl_val = ctrl_reg;
    assign dir_val = dir_reg;
    assign data_val = data_reg;
    assign cfg_val = cfg_reg;
endmodule // hpfs_apb
`default_nettype wire

// File: hpfs_host.sv
// external host side of the three shared pins
// assumes pull-ups on all three pins
`timescale 1ns/10ps
`default_nettype none
module hpfs_host
    import hpfs_pkg::*;
(
    input wire logic [HPFS_NPIN-1:0] pin_out,
    input wire logic [HPFS_NPIN-1:0] pin_oe,
    input wire logic [HPFS_NPIN-1:0] host_val,
    input wire logic [HPFS_NPIN-1:0] host_en,
    output logic [HPFS_NPIN-1:0] pin_in
);
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & (~host_en | host_val));
endmodule // hpfs_host
`default_nettype wire

// File: hpfs_monitor.sv
// checker on hpfs_top ports
// assumes registers change only through apb writes
`timescale 1ns/10ps
`default_nettype none
module hpfs_monitor
    import hpfs_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [HPFS_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic stop_mode,
    input wire logic host_req_core,
    input wire logic xmit_req_core,
    input wire logic recv_req_core,
    input wire logic [HPFS_NPIN-1:0] pin_in,
    input wire logic [HPFS_NPIN-1:0] pin_out,
    input wire logic [HPFS_NPIN-1:0] pin_oe,
    input wire logic host_chip_select_in,
    input wire logic host_addr_line_ten,
    input wire logic host_acknowledge_in,
    input wire logic [HPFS_NPIN-1:0] gpio_in
);
    logic [2:0] ct_reg, s1_reg, s2_reg, dr_reg, dt_reg;
    logic [5:0] cf_reg;
    logic wr, m, db, pl, od, r14;
    // ****
    // shadow state, mirrors the registers and the pin synchroniser
    // ****
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ct_reg <= 3'h0;
            dr_reg <= 3'h0;
            dt_reg <= 3'h0;
            cf_reg <= 6'h00;
            s1_reg <= 3'h0;
            s2_reg <= 3'h0;
        end else begin
            s1_reg <= pin_in;
            s2_reg <= s1_reg;
            if (wr && paddr == HPFS_OFS_CTRL) ct_reg <= pwdata[2:0];
            if (wr && paddr == HPFS_OFS_DIR) dr_reg <= pwdata[2:0];
            if (wr && paddr == HPFS_OFS_DATA) dt_reg <= pwdata[2:0];
            if (wr && paddr == HPFS_OFS_CFG) cf_reg <= pwdata[5:0];
        end
    end
    assign wr = psel && penable && pwrite && pready;
    assign m = cf_reg[HPFS_CFG_MUX];
    assign db = cf_reg[HPFS_CFG_DBLREQ];
    assign pl = cf_reg[HPFS_CFG_REQ_POL];
    assign od = cf_reg[HPFS_CFG_REQ_OD];
    assign r14 = db ? xmit_req_core : host_req_core;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    property p_req14;
        !(ct_reg[1] && m) |=> pin_oe[1] == $past(!od || r14)
            && (!pin_oe[1] || pin_out[1] == $past(r14 ~^ pl));
    endproperty
    a_req14: assert property (p_req14) else $error("pin14 request");
    property p_req15;
        !ct_reg[2] && db |=> pin_oe[2] == $past(!od || recv_req_core)
            && (!pin_oe[2] || pin_out[2] == $past(recv_req_core ~^ pl));
    endproperty
    a_req15: assert property (p_req15) else $error("pin15 request");
    property p_ack;
        !ct_reg[2] && !db |=> host_acknowledge_in == $past(s2_reg[2] == cf_reg[HPFS_CFG_ACK_POL]);
    endproperty
    a_ack: assert property (p_ack) else $error("ack level");
    property p_cs;
        !ct_reg[0] |=> host_chip_select_in == $past(!m && s2_reg[0] == cf_reg[HPFS_CFG_CS_POL]);
    endproperty
    a_cs: assert property (p_cs) else $error("chip select");
    property p_a10;
        !ct_reg[0] |=> host_addr_line_ten == $past(m && s2_reg[0]);
    endproperty
    a_a10: assert property (p_a10) else $error("addr ten");
    property p_p13;
        !ct_reg[0] || stop_mode |=> !pin_oe[0];
    endproperty
    a_p13: assert property (p_p13) else $error("pin13 driven");
    property p_gin;
        stop_mode [*2] |-> $stable(gpio_in);
    endproperty
    a_gin: assert property (p_gin) else $error("gpio in moved");
    property p_err;
        psel && penable && (paddr > HPFS_OFS_HOST || paddr[1:0] != 2'h0) |-> pslverr;
    endproperty
    a_err: assert property (p_err) else $error("no slave error"); // unmapped offset
    property p_gpio13;
        ct_reg[0] && !stop_mode |=> pin_oe[0] == $past(dr_reg[0])
            && pin_out[0] == $past(dt_reg[0]);
    endproperty
    a_gpio13: assert property (p_gpio13) else $error("pin13 gpio drive");
    cover property (host_acknowledge_in);
    cover property (pin_oe[2] && db);
    cover property (stop_mode && gpio_in[1]);
endmodule // hpfs_monitor
bind hpfs_top hpfs_monitor u_mon (.clk_sys, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pready, .pslverr, .stop_mode, .host_req_core, .xmit_req_core, .recv_req_core, .pin_in,
    .pin_out, .pin_oe, .host_chip_select_in, .host_addr_line_ten, .host_acknowledge_in, .gpio_in);
`default_nettype wire

// File: hpfs_pkg.sv
// package for the host port pin function select block
// assumes a single clk_sys domain and an apb register slave
package hpfs_pkg;
    // ******************************************
    // register byte offsets
    // ******************************************
    localparam logic [7:0] HPFS_OFS_CTRL = 8'h00;
    localparam logic [7:0] HPFS_OFS_DIR = 8'h04;
    localparam logic [7:0] HPFS_OFS_DATA = 8'h08;
    localparam logic [7:0] HPFS_OFS_CFG = 8'h0c;
    localparam logic [7:0] HPFS_OFS_PINS = 8'h10;
    localparam logic [7:0] HPFS_OFS_HOST = 8'h14;
    localparam int HPFS_ADDR_W = 8;
    // ******************************************
    // port bits, index within the three-pin group
    // ******************************************
    localparam int HPFS_NPIN = 3;
    localparam int HPFS_PIN13 = 0;
    localparam int HPFS_PIN14 = 1;
    localparam int HPFS_PIN15 = 2;
    // ******************************************
    // config register fields
    // ******************************************
    localparam int HPFS_CFG_MUX = 0;
    localparam int HPFS_CFG_DBLREQ = 1;
    localparam int HPFS_CFG_CS_POL = 2;
    localparam int HPFS_CFG_REQ_POL = 3;
    localparam int HPFS_CFG_REQ_OD = 4;
    localparam int HPFS_CFG_ACK_POL = 5;
    localparam int HPFS_CFG_W = 6;
    // ******************************************
    // host status register fields
    // ******************************************
    localparam int HPFS_HST_CS = 0;
    localparam int HPFS_HST_A10 = 1;
    localparam int HPFS_HST_ACK = 2;
    localparam int HPFS_HST_W = 3;
    // ******************************************
    // reset values
    // ******************************************
    localparam logic [HPFS_NPIN-1:0] HPFS_RST_CTRL = 3'h0;
    localparam logic [HPFS_NPIN-1:0] HPFS_RST_DIR = 3'h0;
    localparam logic [HPFS_NPIN-1:0] HPFS_RST_DATA = 3'h0;
    localparam logic [HPFS_CFG_W-1:0] HPFS_RST_CFG = 6'h00;
    localparam logic [31:0] HPFS_RD_ZERO = 32'h0000_0000;
endpackage : hpfs_pkg

// File: hpfs_sync.sv
// two flip-flop synchroniser for a group of pin inputs
// assumes inputs are asynchronous to clk_sys
`timescale 1ns/10ps
`default_nettype none
module hpfs_sync #(
    parameter int WIDTH = 3
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] meta_next;
    logic [WIDTH-1:0] sync_reg;
    logic [WIDTH-1:0] sync_next;

    // first stage feeds only the second
    always_comb begin
        meta_next = async_in;
        sync_next = meta_reg;
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else begin
            meta_reg <= meta_next;
            sync_reg <= sync_next;
        end
    end

    assign sync_out = sync_reg;
endmodule // hpfs_sync
`default_nettype wire

// File: hpfs_top.sv
// pin function select for the three shared host port pins
// assumes host bus pins asynchronous to clk_sys; pad logic resolves oe
`timescale 1ns/10ps
`default_nettype none
// What this block does
// RULE_01 - non-multiplexed bus with host function uses pin 13 as chip select of set polarity.
// RULE_02 - multiplexed bus with host function uses pin 13 as host address bit ten.
// RULE_03 - a pin given to general-purpose use is input or output by its direction bit.
// RULE_04 - pin 14 is general-purpose only on a multiplexed bus with its control bit set.
// RULE_05 - single-request mode with host function drives pin 14 as host request.
// RULE_06 - a config bit sets the active level of every host request output.
// RULE_07 - a config bit makes request outputs either driven or open-drain.
// RULE_08 - double-request mode drives pin 14 as transmit and pin 15 as receive request.
// RULE_09 - single-request mode reads pin 15 as acknowledge at the configured polarity.
// RULE_10 - in stop mode general-purpose pins are cut off from the core.
// RULE_11 - a host-function pin ignores its direction and data bits.
module hpfs_top
    import hpfs_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [HPFS_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic stop_mode,
    input wire logic host_req_core,
    input wire logic xmit_req_core,
    input wire logic recv_req_core,
    input wire logic [HPFS_NPIN-1:0] pin_in,
    output logic [HPFS_NPIN-1:0] pin_out,
    output logic [HPFS_NPIN-1:0] pin_oe,
    output logic host_chip_select_in,
    output logic host_addr_line_ten,
    output logic host_acknowledge_in,
    output logic [HPFS_NPIN-1:0] gpio_in
);
    logic [HPFS_NPIN-1:0] ctrl_val;
    logic [HPFS_NPIN-1:0] dir_val;
    logic [HPFS_NPIN-1:0] data_val;
    logic [HPFS_CFG_W-1:0] cfg_val;
    logic [HPFS_NPIN-1:0] pin_sync;
    logic mux_bus, dbl_req, req_od, req_pol;
    logic [HPFS_NPIN-1:0] gpio_sel;
    logic [HPFS_NPIN-1:0] out_next, oe_next, out_reg, oe_reg;
    logic [HPFS_NPIN-1:0] gin_next, gin_reg;
    logic cs_next, a10_next, ack_next, cs_reg, a10_reg, ack_reg;

    // ******************************************
    // register slave and pin synchroniser
    // ******************************************
    hpfs_apb u_apb (
        .clk_sys(clk_sys),
        .rst(rst),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .pin_state(gin_reg),
        .host_state({ack_reg, a10_reg, cs_reg}),
        .ctrl_val(ctrl_val),
        .dir_val(dir_val),
        .data_val(data_val),
        .cfg_val(cfg_val)
    );

    hpfs_sync #(.WIDTH(HPFS_NPIN)) u_sync (
        .clk_sys(clk_sys),
        .rst(rst),
        .async_in(pin_in),
        .sync_out(pin_sync)
    );

    // ******************************************
    // function selection
    // ******************************************
    // request level toward the pad: polarity applied, od pulls only when active
    function automatic void req_drive(input logic active, input logic pol, input logic od,
                                      output logic val, output logic en);
        val = active ? pol : !pol;
        en = od ? active : 1'b1;
    endfunction

    assign mux_bus = cfg_val[HPFS_CFG_MUX];
    assign dbl_req = cfg_val[HPFS_CFG_DBLREQ];
    assign req_od = cfg_val[HPFS_CFG_REQ_OD];
    assign req_pol = cfg_val[HPFS_CFG_REQ_POL];

    always_comb begin
        gpio_sel = ctrl_val;
        // RULE_04 pin 14 gpio gate
        gpio_sel[HPFS_PIN14] = ctrl_val[HPFS_PIN14] && mux_bus;
    end

    always_comb begin
        out_next = '0;
        oe_next = '0;
        gin_next = gin_reg;
        cs_next = 1'b0;
        a10_next = 1'b0;
        ack_next = 1'b0;
        for (int i = 0; i < HPFS_NPIN; i++) begin
            if (gpio_sel[i]) begin
                // RULE_03 per-pin direction
                out_next[i] = data_val[i];
                oe_next[i] = dir_val[i];
                gin_next[i] = pin_sync[i];
                // RULE_10 stop isolates gpio
                if (stop_mode) begin
                    oe_next[i] = 1'b0;
                    gin_next[i] = gin_reg[i];
                end
            end
        end
        // RULE_11 host pins ignore gpio bits
        if (!gpio_sel[HPFS_PIN13]) begin
            if (mux_bus) begin
                // RULE_02 address bit ten
                a10_next = pin_sync[HPFS_PIN13];
            end else begin
                // RULE_01 chip select polarity
                cs_next = pin_sync[HPFS_PIN13] == cfg_val[HPFS_CFG_CS_POL];
            end
        end
        if (!gpio_sel[HPFS_PIN14]) begin
            // RULE_05 single request drive, RULE_06 polarity, RULE_07 od choice
            req_drive(dbl_req ? xmit_req_core : host_req_core, req_pol, req_od,
                      out_next[HPFS_PIN14], oe_next[HPFS_PIN14]);
        end
        if (!gpio_sel[HPFS_PIN15]) begin
            if (dbl_req) begin
                // RULE_08 receive request on pin 15
                req_drive(recv_req_core, req_pol, req_od,
                          out_next[HPFS_PIN15], oe_next[HPFS_PIN15]);
            end else begin
                // RULE_09 acknowledge polarity
                ack_next = pin_sync[HPFS_PIN15] == cfg_val[HPFS_CFG_ACK_POL];
            end
        end
    end

    // outputs from flops; one cycle after the select change
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            out_reg <= '0;
            oe_reg <= '0;
            gin_reg <= '0;
            cs_reg <= 1'b0;
            a10_reg <= 1'b0;
            ack_reg <= 1'b0;
        end else begin
            out_reg <= out_next;
            oe_reg <= oe_next;
            gin_reg <= gin_next;
            cs_reg <= cs_next;
            a10_reg <= a10_next;
            ack_reg <= ack_next;
        end
    end

    assign pin_out = out_reg;
    assign pin_oe = oe_reg;
    assign gpio_in = gin_reg;
    assign host_chip_select_in = cs_reg;
    assign host_addr_line_ten = a10_reg;
    assign host_acknowledge_in = ack_reg;
endmodule // hpfs_top
`default_nettype wire
